// file: hw/bfr_defines.svh
/*
  constants of the boot rom access port: register offsets, field
  positions, reset values and rom pin timing.
  assumes a 40 mhz clock and byte addressed wishbone offsets.
*/
`ifndef BFR_DEFINES_SVH
`define BFR_DEFINES_SVH

// register byte offsets
`define BFR_REG_ROM_PORT   8'ha0
`define BFR_REG_LED_CFG    8'h90

// boot_rom_access_port fields
`define BFR_SEL_BIT        31
`define BFR_REN_BIT        27
`define BFR_WEN_BIT        26
`define BFR_ADDR_HI        24
`define BFR_ADDR_LO        8
`define BFR_DATA_HI        7
`define BFR_DATA_LO        0
`define BFR_SEL_RESET      1'b1
`define BFR_ADDR_RESET     17'h0_0000
`define BFR_DATA_RESET     8'h00

// led_config_register fields
`define BFR_LED_MODE_BIT   23
`define BFR_LED_MODE_RESET 1'b0

// rom pin timing
`define BFR_CLK_NS         25
`define BFR_ROM_READ_NS    150
`define BFR_ROM_WRITE_NS   100
`define BFR_RD_CYC   ((`BFR_ROM_READ_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS)
`define BFR_WR_CYC   ((`BFR_ROM_WRITE_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS)
`define BFR_RD_HOLD_CYC    2
`define BFR_WR_HOLD_CYC    1

`endif

// file: hw/bfr_pkg.sv
/*
  types shared by the boot rom access port modules.
  assumes bfr_defines.svh holds the numeric constants.
*/
package bfr_pkg;

  typedef enum logic [2:0] {
    BFR_ST_IDLE   = 3'b000,
    BFR_ST_SETUP  = 3'b001,
    BFR_ST_STROBE = 3'b010,
    BFR_ST_HOLD   = 3'b011,
    BFR_ST_DONE   = 3'b100
  } bfr_state_e;

  typedef logic [16:0] bfr_addr_t;
  typedef logic [7:0]  bfr_byte_t;

endpackage : bfr_pkg

// file: hw/bfr_rom_cycle.sv
/*
  one byte cycle on a parallel flash or boot rom: chip enable, output
  enable and write strobe timing, data capture through a synchroniser.
  assumes the rom answers within the read access time and latches on the
  rising write strobe; start is held until idle drops.
*/
`timescale 1ns/1ps
`include "bfr_defines.svh"

module bfr_rom_cycle (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire bfr_pkg::bfr_addr_t addr_i,
  input  wire bfr_pkg::bfr_byte_t wdata_i,
  output logic                   idle_o,
  output logic                   done_o,
  output bfr_pkg::bfr_byte_t     rdata_o,
  output bfr_pkg::bfr_addr_t     rom_addr_o,
  output bfr_pkg::bfr_byte_t     rom_data_o,
  input  wire bfr_pkg::bfr_byte_t rom_data_i,
  output logic                   rom_data_oe_n_o,
  output logic                   rom_ce_n_o,
  output logic                   rom_oe_n_o,
  output logic                   rom_we_n_o
);
  import bfr_pkg::*;

  bfr_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic       wr, next_wr;
  bfr_addr_t  next_addr;
  bfr_byte_t  next_dout, next_rdata;
  logic       next_doe_n, next_ce_n, next_oe_n, next_we_n;
  bfr_byte_t  din_meta, din_sync;

  assign idle_o = (state == BFR_ST_IDLE);
  assign done_o = (state == BFR_ST_DONE);

  // rom data pins are asynchronous to us, two flops before use
  always_ff @(posedge clk_i) begin
    din_meta <= rom_data_i;
    din_sync <= din_meta;
  end

  // cycle sequencer, all pins come straight from flops to avoid glitches
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_addr  = rom_addr_o;
    next_dout  = rom_data_o;
    next_rdata = rdata_o;
    next_doe_n = rom_data_oe_n_o;
    next_ce_n  = rom_ce_n_o;
    next_oe_n  = rom_oe_n_o;
    next_we_n  = rom_we_n_o;
    case (state)
      BFR_ST_IDLE: begin
        if (start_i) begin
          next_state = BFR_ST_SETUP;
          next_wr    = write_i;
          next_addr  = addr_i;
          next_dout  = wdata_i;
          next_ce_n  = 1'b0;
          next_oe_n  = write_i;
          next_doe_n = ~write_i; // low while we drive the bus
        end
      end
      BFR_ST_SETUP: begin
        // address settles one cycle before the write strobe; a read drops oe with the address
        next_state = BFR_ST_STROBE;
        next_cnt   = wr ? 4'(`BFR_WR_CYC - 1) : 4'(`BFR_RD_CYC - 1);
        next_we_n  = ~wr;
      end
      BFR_ST_STROBE: begin
        if (cnt == 4'h0) begin
          next_state = BFR_ST_HOLD;
          next_we_n  = 1'b1; // rom latches on this rising edge
          next_cnt   = wr ? 4'(`BFR_WR_HOLD_CYC - 1)
                          : 4'(`BFR_RD_HOLD_CYC - 1);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BFR_ST_HOLD: begin
        // read keeps oe low until the synchroniser has the byte
        if (cnt == 4'h0) begin
          next_state = BFR_ST_DONE;
          if (!wr) begin
            next_rdata = din_sync;
          end
          next_ce_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_doe_n = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BFR_ST_DONE: begin
        next_state = BFR_ST_IDLE;
      end
      default: begin
        next_state = BFR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= BFR_ST_IDLE;
      cnt             <= 4'h0;
      wr              <= 1'b0;
      rom_addr_o      <= 17'h0_0000;
      rom_data_o      <= 8'h00;
      rdata_o         <= 8'h00;
      rom_data_oe_n_o <= 1'b1;
      rom_ce_n_o      <= 1'b1;
      rom_oe_n_o      <= 1'b1;
      rom_we_n_o      <= 1'b1;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      wr              <= next_wr;
      rom_addr_o      <= next_addr;
      rom_data_o      <= next_dout;
      rdata_o         <= next_rdata;
      rom_data_oe_n_o <= next_doe_n;
      rom_ce_n_o      <= next_ce_n;
      rom_oe_n_o      <= next_oe_n;
      rom_we_n_o      <= next_we_n;
    end
  end

endmodule : bfr_rom_cycle

// file: hw/bfr_port.sv
/*
  boot rom access port: wishbone register slave holding the rom port and
  the four-led mode bit, launching byte cycles on the rom pins and
  steering the shared address bit 16 / led pin.
  assumes a classic wishbone master on clk_i and an led source on the
  same clock. software keeps to one rom access at a time; a port write
  made while an access runs is acked and dropped, so no pin except the
  shared address bit 16 / led pin changes in mid-cycle.

// Contract
// - a set read enable fetches the addressed byte, then clears itself.
// - a set write enable writes the data byte, then clears when done.
// - address in bits 24..8 and data in bits 7..0, both reset to zero.
// - select bit 31, reset to one, counts only in four-led mode (bit 23).
// - four-led mode: pin is address bit 16 if select is set, else the led.
*/
`timescale 1ns/1ps
`include "bfr_defines.svh"

module bfr_port (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         led_fd_col_i,
  output logic              rom_addr16_led_o,
  output logic [15:0]       rom_addr_o,
  output bfr_pkg::bfr_byte_t rom_data_o,
  input  wire bfr_pkg::bfr_byte_t rom_data_i,
  output logic              rom_data_oe_n_o,
  output logic              rom_ce_n_o,
  output logic              rom_oe_n_o,
  output logic              rom_we_n_o
);
  import bfr_pkg::*;

  // register state
  logic      sel_a16, next_sel_a16;
  logic      ren, next_ren;
  logic      wen, next_wen;
  bfr_addr_t addr, next_addr;
  bfr_byte_t data, next_data;
  logic      led_mode, next_led_mode;
  logic      next_ack;
  logic [31:0] next_dat;
  logic      next_pin16;

  // link to the rom cycle engine
  logic      cyc_idle, cyc_done;
  bfr_byte_t cyc_rdata;
  bfr_addr_t cyc_addr;

  logic        req, wr_go, busy;
  logic        port_hit, led_hit;
  logic [31:0] port_word, led_word, wmerged, lmerged;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] bfr_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : bfr_merge

  // word-address compare against a register offset
  function automatic logic bfr_hit(input logic [7:0] adr,
                                   input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction : bfr_hit

  // register images as seen by software, reserved bits read zero
  // images are plain wiring, so a read returns the state of this cycle
  always_comb begin
    port_word = 32'h0000_0000;
    port_word[`BFR_SEL_BIT] = sel_a16;
    port_word[`BFR_REN_BIT] = ren;
    port_word[`BFR_WEN_BIT] = wen;
    port_word[`BFR_ADDR_HI:`BFR_ADDR_LO] = addr;
    port_word[`BFR_DATA_HI:`BFR_DATA_LO] = data;
    led_word = 32'h0000_0000;
    led_word[`BFR_LED_MODE_BIT] = led_mode;
  end

  // request decode; the write waits for the ack edge so it lands once
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_go    = req & wb_we_i & wb_ack_o; // write lands on the ack edge
  assign busy     = ren | wen;
  assign port_hit = bfr_hit(wb_adr_i, `BFR_REG_ROM_PORT);
  assign led_hit  = bfr_hit(wb_adr_i, `BFR_REG_LED_CFG);

  // bus answer: ack one cycle after the request, unmapped reads give zero
  // one fixed wait state, so the master never needs a timeout here
  always_comb begin
    next_ack = req & ~wb_ack_o;
    next_dat = wb_dat_o;
    if (req & ~wb_ack_o) begin
      if (port_hit) begin
        next_dat = port_word;
      end else if (led_hit) begin
        next_dat = led_word;
      end else begin
        next_dat = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // register writes and hardware completion of an access
  always_comb begin
    next_sel_a16  = sel_a16;
    next_ren      = ren;
    next_wen      = wen;
    next_addr     = addr;
    next_data     = data;
    next_led_mode = led_mode;
    wmerged       = bfr_merge(port_word, wb_dat_i, wb_sel_i);
    lmerged       = bfr_merge(led_word, wb_dat_i, wb_sel_i);
    // a port write during an access is dropped so the pins stay stable
    if (wr_go && port_hit && !busy) begin
      next_sel_a16 = wmerged[`BFR_SEL_BIT];
      next_addr    = wmerged[`BFR_ADDR_HI:`BFR_ADDR_LO];
      next_data    = wmerged[`BFR_DATA_HI:`BFR_DATA_LO];
      // both set: read wins, a misuse the software must avoid
      next_ren     = wmerged[`BFR_REN_BIT];
      next_wen     = wmerged[`BFR_WEN_BIT] & ~wmerged[`BFR_REN_BIT];
    end
    // four-led mode only; the other bits of that register read zero
    if (wr_go && led_hit) begin
      next_led_mode = lmerged[`BFR_LED_MODE_BIT];
    end
    if (cyc_done) begin
      if (ren) begin
        next_data = cyc_rdata;
      end
      next_ren = 1'b0;
      next_wen = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_a16  <= `BFR_SEL_RESET;
      ren      <= 1'b0;
      wen      <= 1'b0;
      addr     <= `BFR_ADDR_RESET;
      data     <= `BFR_DATA_RESET;
      led_mode <= `BFR_LED_MODE_RESET;
    end else begin
      sel_a16  <= next_sel_a16;
      ren      <= next_ren;
      wen      <= next_wen;
      addr     <= next_addr;
      data     <= next_data;
      led_mode <= next_led_mode;
    end
  end

  // the engine starts whenever an enable stands and it is idle; the
  // enable is cleared on the done cycle so no second cycle follows
  // idle gating keeps a standing enable from reaching a busy engine
  bfr_rom_cycle u_cycle (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .start_i         (busy & cyc_idle),
    .write_i         (wen),
    .addr_i          (addr),
    .wdata_i         (data),
    .idle_o          (cyc_idle),
    .done_o          (cyc_done),
    .rdata_o         (cyc_rdata),
    .rom_addr_o      (cyc_addr),
    .rom_data_o      (rom_data_o),
    .rom_data_i      (rom_data_i),
    .rom_data_oe_n_o (rom_data_oe_n_o),
    .rom_ce_n_o      (rom_ce_n_o),
    .rom_oe_n_o      (rom_oe_n_o),
    .rom_we_n_o      (rom_we_n_o)
  );

  assign rom_addr_o = cyc_addr[15:0];

  // shared pin: outside four-led mode it is always address bit 16
  // the led path is registered too, so the pin lags its source a cycle
  always_comb begin
    next_pin16 = cyc_addr[16];
    if (led_mode && !sel_a16) begin
      next_pin16 = led_fd_col_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rom_addr16_led_o <= 1'b0;
    end else begin
      rom_addr16_led_o <= next_pin16;
    end
  end

endmodule : bfr_port

// file: test/bfr_port_properties.sv
/*
  checker for the boot rom access port: bus ack timing and rom strobes.
  assumes it is bound to bfr_port and sees only its ports.
*/
`timescale 1ns/1ps
module bfr_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rom_ce_n_o,
  input wire logic rom_oe_n_o,
  input wire logic rom_we_n_o,
  input wire logic rom_data_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // write strobe: four low cycles, then released
  sequence s_we_pulse;
    !rom_we_n_o [*4] ##1 rom_we_n_o;
  endsequence
  // read strobe covers access time plus hold
  sequence s_oe_span;
    !rom_oe_n_o [*8];
  endsequence

  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o
    |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_we_width: assert property ($fell(rom_we_n_o) |-> s_we_pulse)
    else $error("write strobe width wrong");
  chk_oe_width: assert property ($fell(rom_oe_n_o) |-> s_oe_span)
    else $error("read strobe too short");
  chk_strobe_excl: assert property (!(!rom_oe_n_o && !rom_we_n_o))
    else $error("read and write strobes together");
  chk_ce_covers: assert property ((!rom_oe_n_o || !rom_we_n_o)
    |-> !rom_ce_n_o) else $error("strobe without chip enable");
  chk_write_drive: assert property (!rom_we_n_o |-> !rom_data_oe_n_o)
    else $error("data not driven in write");
  chk_read_float: assert property (!rom_oe_n_o |-> rom_data_oe_n_o)
    else $error("data driven during read");
endmodule : bfr_port_properties

// file: test/bfr_rom_model.sv
/*
  behavioural parallel boot rom: byte store, read while selected.
  assumes address bit 16 arrives on the shared pin.
*/
`timescale 1ns/1ps
module bfr_rom_model (
  input  wire logic        clk_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i
);
  logic [7:0] mem [bit [16:0]];
  initial rdata_o = 8'h00;

  // unselected bus toggles so a stale byte is never mistaken for data
  always @(posedge clk_i) begin
    if (!ce_n_i && !oe_n_i)
      rdata_o <= mem.exists(addr_i) ? mem[addr_i] : addr_i[7:0] ^ 8'h5a;
    else
      rdata_o <= ~rdata_o;
  end

  // byte latched on the rising write strobe
  always @(posedge we_n_i) begin
    if (!ce_n_i) mem[addr_i] = wdata_i;
  end
endmodule : bfr_rom_model

// file: test/tb_top.sv
/*
  testbench of the boot rom access port over classic wishbone.
  assumes bfr_port, the rom model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
  logic        wb_we_i = 0, led_fd_col_i = 0, wb_ack_o, rom_addr16_led_o;
  logic        rom_data_oe_n_o, rom_ce_n_o, rom_oe_n_o, rom_we_n_o;
  logic [7:0]  wb_adr_i = 8'h00, rom_data_o, rom_data_i;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] rom_addr_o;
  int          failures = 0, total_checks = 0;

  always #12.5 clk_i = ~clk_i;

  bfr_port i_bfr_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .led_fd_col_i(led_fd_col_i),
    .rom_addr16_led_o(rom_addr16_led_o), .rom_addr_o(rom_addr_o),
    .rom_data_o(rom_data_o), .rom_data_i(rom_data_i),
    .rom_data_oe_n_o(rom_data_oe_n_o), .rom_ce_n_o(rom_ce_n_o),
    .rom_oe_n_o(rom_oe_n_o), .rom_we_n_o(rom_we_n_o));
  bfr_rom_model i_rom (.clk_i(clk_i), .addr_i({rom_addr16_led_o, rom_addr_o}),
    .wdata_i(rom_data_o), .rdata_o(rom_data_i), .ce_n_i(rom_ce_n_o),
    .oe_n_i(rom_oe_n_o), .we_n_i(rom_we_n_o));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one classic cycle; ack and data taken at the same edge
  task automatic wb_io(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 20) begin
      failures++;
      finish_test();
    end
  endtask : wb_io

  function automatic logic [31:0] pw(logic ren, wen, sel, logic [16:0] a,
                                     logic [7:0] d);
    return {sel, 3'h0, ren, wen, 1'b0, a, d};
  endfunction : pw

  // poll until the enable bit drops, bounded
  task automatic poll(input int b);
    int n = 0;
    do begin
      wb_io(0, 8'ha0, 0);
    end while (rd[b] && ++n < 40);
    if (rd[b]) begin
      failures++;
      finish_test();
    end
  endtask : poll

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb_io(0, 8'ha0, 0);
    check("port_reset", rd, 32'h8000_0000);
    wb_io(0, 8'h90, 0);
    check("led_reset", rd, 32'h0);
    wb_io(0, 8'h40, 0);
    check("unmapped", rd, 32'h0);
    check("pin_reset", rom_addr16_led_o, 0);
    $display("test reset done");
    wb_io(1, 8'ha0, pw(0, 1, 1, 17'h1_2345, 8'h3c));
    poll(26);
    check("wen_clear", rd, pw(0, 0, 1, 17'h1_2345, 8'h3c));
    check("rom_byte", {24'h0, i_rom.mem[17'h1_2345]}, 32'h3c);
    check("pin_a16", rom_addr16_led_o, 1);
    wb_io(1, 8'ha0, pw(1, 0, 1, 17'h1_2345, 8'h00));
    poll(27);
    check("ren_data", rd, pw(0, 0, 1, 17'h1_2345, 8'h3c));
    $display("test write read done");
    wb_io(1, 8'ha0, pw(1, 0, 1, 17'h0_00a7, 8'h00));
    wb_io(1, 8'ha0, pw(0, 0, 1, 17'h0_0055, 8'h11));
    poll(27);
    check("busy_read", rd, pw(0, 0, 1, 17'h0_00a7, 8'hfd));
    check("pin_a16_low", rom_addr16_led_o, 0);
    $display("test busy read done");
    wb_io(1, 8'h90, 32'h0080_0000);
    wb_io(1, 8'ha0, pw(0, 0, 0, 17'h1_0000, 8'h00));
    for (int v = 0; v < 2; v++) begin
      led_fd_col_i <= v[0];
      repeat (3) @(posedge clk_i);
      check("pin_led", rom_addr16_led_o, v[0]);
    end
    led_fd_col_i <= 0;
    wb_io(1, 8'ha0, pw(1, 0, 1, 17'h1_0000, 8'h00));
    poll(27);
    check("led_mode_read", rd, pw(0, 0, 1, 17'h1_0000, 8'h5a));
    check("pin_sel", rom_addr16_led_o, 1);
    $display("test four led done");
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb_io(0, 8'ha0, 0);
    check("port_rerst", rd, 32'h8000_0000);
    wb_io(0, 8'h90, 0);
    check("led_rerst", rd, 32'h0);
    check("pin_rerst", rom_addr16_led_o, 0);
    $display("test mid reset done");
    finish_test();
  end
endmodule : tb_top

bind bfr_port bfr_port_properties i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rom_ce_n_o(rom_ce_n_o), .rom_oe_n_o(rom_oe_n_o),
  .rom_we_n_o(rom_we_n_o), .rom_data_oe_n_o(rom_data_oe_n_o));
